//--- core/sebfe_front_end.sv
`timescale 1ns/1ps
`default_nettype none

module sebfe_front_end
  import sebfe_pkg::*;
#(
  // Device type code; the value is arbitrary.
  parameter logic [3:0] DEV_TYPE_CODE = 4'h6
) (
  input  wire logic        clk,               // System clock, 100 MHz.
  input  wire logic        reset_n,           // Asynchronous reset, active low.
  input  wire logic        clkEn,             // Clock enable, freezes state when low.
  input  wire logic        scl,               // Serial clock pin from the controller.
  input  wire logic        sdaIn,             // Serial data line level.
  output logic             sdaOut,            // Serial data drive value, always low.
  output logic             sdaOe,             // Serial data pull-down enable, high drives.
  input  wire logic [2:0]  chipSelectInputs,  // Hard-wired chip select inputs.
  input  wire logic        writeProtect,      // Protection pin, high blocks writes.
  input  wire logic [1:0]  sizeVariant,       // Size variant selector.
  input  wire logic        opPending,         // Internal operation still running.
  input  wire logic [7:0]  rdData,            // Array byte at memAddr.
  output logic [10:0]      memAddr,           // Current word address counter.
  output logic             rdStrobe,          // Pulse: rdData taken for output.
  output logic             wrStrobe,          // Pulse: wrData to be written at wrAddr.
  output logic [7:0]       wrData,            // Received data byte.
  output logic [10:0]      wrAddr,            // Address for wrData.
  output logic             wrBlocked,         // Pulse: data byte refused by protection.
  output logic             addressed,         // Level: device selected in a transfer.
  output logic             readMode,          // Level: latched read/write select.
  output logic             standby            // Level: low-power standby.
);

  // ---------------------------------------------------------------------------
  // Line conditioning
  // ---------------------------------------------------------------------------
  // Nothing in this module reads the raw scl and sdaIn pins; every bus-line decision uses the conditioned copies.
  sebfe_line_if lineBus ();

  sebfe_line_cond uCond (
    .clk     (clk),
    .reset_n (reset_n),
    .clkEn   (clkEn),
    .sclPin  (scl),
    .sdaPin  (sdaIn),
    .line    (lineBus)
  );

  // ---------------------------------------------------------------------------
  // Address helpers
  // ---------------------------------------------------------------------------
  function automatic logic [10:0] arrayMask(input logic [1:0] v);
    unique case (v)
      VAR_2K:  arrayMask = ARRAY_MASK_2K;
      VAR_4K:  arrayMask = ARRAY_MASK_4K;
      VAR_8K:  arrayMask = ARRAY_MASK_8K;
      VAR_16K: arrayMask = ARRAY_MASK_16K;
    endcase
  endfunction

  function automatic logic [10:0] pageMask(input logic [1:0] v);
    pageMask = (v == VAR_2K) ? PAGE_MASK_8B : PAGE_MASK_16B;
  endfunction

  // Writes wrap inside the page; reads wrap over the whole array.
  function automatic logic [10:0] incPage(input logic [10:0] a, input logic [1:0] v);
    logic [10:0] step;
    step    = a + 11'h001;
    incPage = (a & ~pageMask(v)) | (step & pageMask(v));
  endfunction

  function automatic logic [10:0] incArray(input logic [10:0] a, input logic [1:0] v);
    logic [10:0] step;
    step     = a + 11'h001;
    incArray = step & arrayMask(v);
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  // The address counter survives stop and mismatch and is cleared only by reset,
  // so a current address read carries on from the last access.
  sebfe_state_t state_reg, state_next;
  sebfe_kind_t  kind_reg,  kind_next;
  logic [3:0]   bitCnt_reg,   bitCnt_next;
  logic [7:0]   shift_reg,    shift_next;
  logic [10:0]  wordAddr_reg, wordAddr_next;
  logic [2:0]   page_reg,     page_next;
  logic         rw_reg,       rw_next;
  logic         oe_reg,       oe_next;
  logic         mAck_reg,     mAck_next;
  logic         wrStb_reg,    wrStb_next;
  logic         rdStb_reg,    rdStb_next;
  logic         blk_reg,      blk_next;
  logic [7:0]   wrData_reg,   wrData_next;
  logic [10:0]  wrAddr_reg,   wrAddr_next;

  // ---------------------------------------------------------------------------
  // Device address decode
  // ---------------------------------------------------------------------------
  // Select pins that a size does not compare are don't-care, so any strap level is safe.
  wire [3:0] devType   = shift_reg[DEV_TYPE_MSB:DEV_TYPE_LSB];
  wire [2:0] devSel    = shift_reg[DEV_SEL_MSB:DEV_SEL_LSB];
  wire       typeMatch = (devType == DEV_TYPE_CODE);
  wire       selMatch2 = (devSel == chipSelectInputs);
  wire       selMatch4 = (devSel[2:1] == chipSelectInputs[2:1]);
  wire       selMatch8 = (devSel[2] == chipSelectInputs[2]);
  wire       selMatch  = (sizeVariant == VAR_2K) ? selMatch2 :
                         (sizeVariant == VAR_4K) ? selMatch4 :
                         (sizeVariant == VAR_8K) ? selMatch8 : 1'b1;
  wire       devMatch  = typeMatch & selMatch;
  wire [2:0] pageBits  = (sizeVariant == VAR_2K) ? 3'h0 :
                         (sizeVariant == VAR_4K) ? {2'h0, devSel[0]} :
                         (sizeVariant == VAR_8K) ? {1'b0, devSel[1:0]} :
                         devSel;
  wire [10:0] rxWordAddr = {page_reg, shift_reg} & arrayMask(sizeVariant);

  wire byteDone = (bitCnt_reg == BIT_CNT_LAST);
  wire sendLast = (bitCnt_reg == BIT_CNT_LAST);

  // ---------------------------------------------------------------------------
  // Transfer events
  // ---------------------------------------------------------------------------
  // Bits are taken only on a rise and a word ends only on the fall after the
  // eighth bit, so a data change while the clock is low never lands as data.
  wire rxSample  = lineBus.sclRise && !byteDone;
  wire rxWordEnd = lineBus.sclFall && byteDone;

  // ---------------------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------------------
  logic doLoad;

  always_comb begin
    state_next    = state_reg;
    kind_next     = kind_reg;
    bitCnt_next   = bitCnt_reg;
    shift_next    = shift_reg;
    wordAddr_next = wordAddr_reg;
    page_next     = page_reg;
    rw_next       = rw_reg;
    oe_next       = oe_reg;
    mAck_next     = mAck_reg;
    wrStb_next    = 1'b0;
    rdStb_next    = 1'b0;
    blk_next      = 1'b0;
    wrData_next   = wrData_reg;
    wrAddr_next   = wrAddr_reg;
    doLoad        = 1'b0;

    if (lineBus.startSeen) begin
      state_next  = ST_RECV;
      kind_next   = BK_DEV;
      bitCnt_next = BIT_CNT_ZERO;
      oe_next     = 1'b0;
    end else if (lineBus.stopSeen) begin
      state_next = ST_IDLE;
      oe_next    = 1'b0;
    end else begin
      unique case (state_reg)
        // Clock edges here belong to another device's transfer or follow the controller's no-acknowledge, and are ignored.
        ST_IDLE, ST_WAIT: begin
          oe_next = 1'b0;
        end
        ST_RECV: begin
          if (rxSample) begin
            shift_next  = {shift_reg[6:0], lineBus.sdaLvl};
            bitCnt_next = bitCnt_reg + BIT_CNT_FIRST;
          end else if (rxWordEnd) begin
            state_next = ST_ACK;
            oe_next    = 1'b1;
            unique case (kind_reg)
              BK_DEV: begin
                if (devMatch) begin
                  rw_next   = shift_reg[DEV_RW_BIT];
                  page_next = pageBits;
                end else begin
                  state_next = ST_IDLE;
                  oe_next    = 1'b0;
                end
              end
              BK_WADDR: begin
                wordAddr_next = rxWordAddr;
              end
              BK_DATA: begin
                if (writeProtect) begin
                  blk_next = 1'b1;
                end else begin
                  wrStb_next  = 1'b1;
                  wrData_next = shift_reg;
                  wrAddr_next = wordAddr_reg;
                end
                wordAddr_next = incPage(wordAddr_reg, sizeVariant);
              end
            endcase
          end
        end
        ST_ACK: begin
          if (lineBus.sclFall) begin
            oe_next     = 1'b0;
            bitCnt_next = BIT_CNT_ZERO;
            state_next  = ST_RECV;
            if (kind_reg == BK_DEV && rw_reg) begin
              doLoad = 1'b1;
            end else if (kind_reg == BK_DEV) begin
              kind_next = BK_WADDR;
            end else begin
              kind_next = BK_DATA;
            end
          end
        end
        // Only the enable moves; a one is sent by releasing the line to its pull-up.
        ST_SEND: begin
          if (lineBus.sclFall) begin
            if (sendLast) begin
              oe_next    = 1'b0;
              state_next = ST_MACK;
            end else begin
              oe_next     = ~shift_reg[6];
              shift_next  = {shift_reg[6:0], 1'b0};
              bitCnt_next = bitCnt_reg + BIT_CNT_FIRST;
            end
          end
        end
        // The controller's bit is taken at the rise and acted on at the fall, so a
        // following byte always starts on a falling edge.
        ST_MACK: begin
          if (lineBus.sclRise) begin
            mAck_next = ~lineBus.sdaLvl;
          end else if (lineBus.sclFall) begin
            if (mAck_reg) begin
              doLoad = 1'b1;
            end else begin
              state_next = ST_WAIT;
            end
          end
        end
      endcase
    end

    // The first bit goes out on the same falling edge that ends the ack slot.
    if (doLoad) begin
      state_next    = ST_SEND;
      shift_next    = rdData;
      oe_next       = ~rdData[7];
      bitCnt_next   = BIT_CNT_FIRST;
      rdStb_next    = 1'b1;
      wordAddr_next = incArray(wordAddr_reg, sizeVariant);
    end
  end

  // ---------------------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      kind_reg  <= BK_DEV;
    end else if (clkEn) begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bitCnt_reg   <= BIT_CNT_ZERO;
      shift_reg    <= SHIFT_RST;
      wordAddr_reg <= ADDR_RST;
      page_reg     <= PAGE_RST;
      rw_reg       <= 1'b0;
      oe_reg       <= 1'b0;
      mAck_reg     <= 1'b0;
    end else if (clkEn) begin
      bitCnt_reg   <= bitCnt_next;
      shift_reg    <= shift_next;
      wordAddr_reg <= wordAddr_next;
      page_reg     <= page_next;
      rw_reg       <= rw_next;
      oe_reg       <= oe_next;
      mAck_reg     <= mAck_next;
    end
  end

  // Strobes and write data sit apart from the FSM; the data hold until the next
  // byte, so the array side may take them a cycle late.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrStb_reg  <= 1'b0;
      rdStb_reg  <= 1'b0;
      blk_reg    <= 1'b0;
      wrData_reg <= SHIFT_RST;
      wrAddr_reg <= ADDR_RST;
    end else if (clkEn) begin
      wrStb_reg  <= wrStb_next;
      rdStb_reg  <= rdStb_next;
      blk_reg    <= blk_next;
      wrData_reg <= wrData_next;
      wrAddr_reg <= wrAddr_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  // The pad is open drain: the value is always low and only the enable moves.
  assign sdaOut    = 1'b0;
  assign sdaOe     = oe_reg;
  assign memAddr   = wordAddr_reg;
  assign rdStrobe  = rdStb_reg;
  assign wrStrobe  = wrStb_reg;
  assign wrData    = wrData_reg;
  assign wrAddr    = wrAddr_reg;
  assign wrBlocked = blk_reg;
  assign addressed = (state_reg != ST_IDLE) &&
                     !(state_reg == ST_RECV && kind_reg == BK_DEV);
  assign readMode  = rw_reg;
  // Standby waits for the pending operation, so a write cycle is never cut short.
  assign standby   = (state_reg == ST_IDLE) && !opPending;

endmodule // sebfe_front_end

`default_nettype wire

//--- core/sebfe_line_cond.sv
`timescale 1ns/1ps
`default_nettype none

module sebfe_line_cond (
  input  wire logic          clk,       // System clock.
  input  wire logic          reset_n,   // Asynchronous reset, active low.
  input  wire logic          clkEn,     // Clock enable, freezes state when low.
  input  wire logic          sclPin,    // Raw serial clock pin.
  input  wire logic          sdaPin,    // Raw serial data line level.
  sebfe_line_if.producer     line       // Conditioned levels and events.
);

  // ---------------------------------------------------------------------------
  // Synchronisers and edge history
  // ---------------------------------------------------------------------------
  // Only the second stage and the history stage are looked at by logic.
  logic sclMeta_reg;
  logic sclSync_reg;
  logic sclPrev_reg;
  logic sdaMeta_reg;
  logic sdaSync_reg;
  logic sdaPrev_reg;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sclMeta_reg <= 1'b1;
      sclSync_reg <= 1'b1;
      sclPrev_reg <= 1'b1;
      sdaMeta_reg <= 1'b1;
      sdaSync_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else if (clkEn) begin
      sclMeta_reg <= sclPin;
      sclSync_reg <= sclMeta_reg;
      sclPrev_reg <= sclSync_reg;
      sdaMeta_reg <= sdaPin;
      sdaSync_reg <= sdaMeta_reg;
      sdaPrev_reg <= sdaSync_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Events
  // ---------------------------------------------------------------------------
  // A data edge counts only while the clock was high on both samples.
  wire sclHeld = sclSync_reg & sclPrev_reg;

  assign line.sclLvl    = sclSync_reg;
  assign line.sdaLvl    = sdaSync_reg;
  assign line.sclRise   = clkEn & sclSync_reg & ~sclPrev_reg;
  assign line.sclFall   = clkEn & ~sclSync_reg & sclPrev_reg;
  assign line.startSeen = clkEn & sclHeld & sdaPrev_reg & ~sdaSync_reg;
  assign line.stopSeen  = clkEn & sclHeld & ~sdaPrev_reg & sdaSync_reg;

endmodule // sebfe_line_cond

`default_nettype wire

//--- core/sebfe_line_if.sv
`timescale 1ns/1ps
`default_nettype none

interface sebfe_line_if;
  logic sclLvl;
  logic sdaLvl;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;

  modport producer (output sclLvl, sdaLvl, sclRise, sclFall, startSeen, stopSeen);
  modport consumer (input  sclLvl, sdaLvl, sclRise, sclFall, startSeen, stopSeen);
endinterface

`default_nettype wire

//--- core/sebfe_pkg.sv
`default_nettype none

package sebfe_pkg;

  // ---------------------------------------------------------------------------
  // Word and address geometry
  // ---------------------------------------------------------------------------
  localparam int          WORD_BITS     = 8;
  localparam int          ADDR_BITS     = 11;
  localparam int          SEL_BITS      = 3;
  localparam logic [3:0]  BIT_CNT_LAST  = 4'h8;
  localparam logic [3:0]  BIT_CNT_FIRST = 4'h1;
  localparam logic [3:0]  BIT_CNT_ZERO  = 4'h0;

  // ---------------------------------------------------------------------------
  // Size variants
  // ---------------------------------------------------------------------------
  localparam logic [1:0]  VAR_2K  = 2'h0;
  localparam logic [1:0]  VAR_4K  = 2'h1;
  localparam logic [1:0]  VAR_8K  = 2'h2;
  localparam logic [1:0]  VAR_16K = 2'h3;

  // Array masks: 8-, 9-, 10- and 11-bit word addresses.
  localparam logic [10:0] ARRAY_MASK_2K  = 11'h0FF;
  localparam logic [10:0] ARRAY_MASK_4K  = 11'h1FF;
  localparam logic [10:0] ARRAY_MASK_8K  = 11'h3FF;
  localparam logic [10:0] ARRAY_MASK_16K = 11'h7FF;

  // Page offset masks: 8-byte pages (32 of them) or 16-byte pages.
  localparam logic [10:0] PAGE_MASK_8B  = 11'h007;
  localparam logic [10:0] PAGE_MASK_16B = 11'h00F;

  // ---------------------------------------------------------------------------
  // Device address word layout
  // ---------------------------------------------------------------------------
  localparam int          DEV_TYPE_MSB = 7;
  localparam int          DEV_TYPE_LSB = 4;
  localparam int          DEV_SEL_MSB  = 3;
  localparam int          DEV_SEL_LSB  = 1;
  localparam int          DEV_RW_BIT   = 0;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  SHIFT_RST = 8'h00;
  localparam logic [10:0] ADDR_RST  = 11'h000;
  localparam logic [2:0]  PAGE_RST  = 3'h0;

  typedef enum {ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK, ST_WAIT} sebfe_state_t;
  typedef enum {BK_DEV, BK_WADDR, BK_DATA} sebfe_kind_t;

endpackage

`default_nettype wire

//--- dv/sebfe_bus_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module sebfe_bus_ctrl (
  input  wire logic clk,     // Bench clock.
  input  wire logic sdaWire, // Resolved data line.
  output logic      scl,     // Serial clock, stands high outside frames.
  output logic      sdaDrv   // Data drive, high releases to the pull-up.
);
  // ---------------------------------------------------------------------------
  // Bus controller tasks, 80 ns serial clock
  // ---------------------------------------------------------------------------
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic bitOut(input logic b, output logic s);
    wt(2);
    sdaDrv <= b;
    wt(2);
    scl <= 1'b1;
    wt(2);
    s = sdaWire;
    wt(2);
    scl <= 1'b0;
  endtask

  // Longer steps give the device time to release its acknowledge first.
  task automatic start();
    wt(3);
    sdaDrv <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sdaDrv <= 1'b0;
    wt(3);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wt(3);
    sdaDrv <= 1'b0;
    wt(3);
    scl <= 1'b1;
    wt(3);
    sdaDrv <= 1'b1;
    wt(3);
  endtask

  task automatic recover();
    logic s;
    for (int i = 0; i < 9; i++)
      bitOut(1'b1, s);
    start();
  endtask

  task automatic byteTx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitOut(d[i], s);
    bitOut(1'b1, s);
    ack = ~s;
  endtask

  task automatic byteRx(input logic ackIt, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bitOut(1'b1, s);
      d[i] = s;
    end
    bitOut(~ackIt, s);
  endtask
endmodule // sebfe_bus_ctrl

`default_nettype wire

//--- dv/sebfe_front_end_props.sv
`timescale 1ns/1ps
`default_nettype none

module sebfe_front_end_props
  import sebfe_pkg::*;
(
  input wire logic        clk,          // Clock.
  input wire logic        reset_n,      // Reset, active low.
  input wire logic        scl,          // Serial clock pin.
  input wire logic        sdaOut,       // Drive value.
  input wire logic        sdaOe,        // Pull-down enable.
  input wire logic        writeProtect, // Protection pin.
  input wire logic [1:0]  sizeVariant,  // Size variant.
  input wire logic        opPending,    // Internal operation busy.
  input wire logic [10:0] memAddr,      // Address counter.
  input wire logic        rdStrobe,     // Read byte pulse.
  input wire logic        wrStrobe,     // Write byte pulse.
  input wire logic [10:0] wrAddr,       // Write address.
  input wire logic        wrBlocked,    // Refused write pulse.
  input wire logic        addressed,    // Selected level.
  input wire logic        readMode,     // Read select level.
  input wire logic        standby       // Standby level.
);
  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  wire logic [10:0] arrMask = (sizeVariant == VAR_2K) ? ARRAY_MASK_2K :
                              (sizeVariant == VAR_4K) ? ARRAY_MASK_4K :
                              (sizeVariant == VAR_8K) ? ARRAY_MASK_8K : ARRAY_MASK_16K;

  chk_open_drain: assert property (sdaOut == 1'b0)
    else $error("data line driven high");
  chk_write_ack: assert property (wrStrobe |-> sdaOe)
    else $error("write byte without acknowledge");
  chk_protect_write: assert property (wrStrobe |-> !writeProtect)
    else $error("write passed while protected");
  chk_protect_block: assert property (wrBlocked |-> writeProtect && !wrStrobe)
    else $error("byte refused without protection");
  chk_read_select: assert property (rdStrobe |-> readMode)
    else $error("read byte outside read mode");
  chk_write_select: assert property (wrStrobe |-> !readMode)
    else $error("write byte in read mode");
  chk_addr_range: assert property (wrStrobe |-> (wrAddr & ~arrMask) == 11'h000)
    else $error("write address beyond array");
  chk_read_wrap: assert property (rdStrobe |-> memAddr == (($past(memAddr) + 11'h001) & arrMask))
    else $error("read address step wrong");
  chk_standby_state: assert property (standby |-> !opPending && !addressed)
    else $error("standby while busy");
  chk_sample_edge: assert property (scl [*3] |-> $stable(sdaOe))
    else $error("data drive changed with clock high");
  chk_pulse_once: assert property (wrStrobe |=> !wrStrobe)
    else $error("write pulse too long");
endmodule // sebfe_front_end_props

bind sebfe_front_end sebfe_front_end_props u_props (.clk, .reset_n, .scl, .sdaOut, .sdaOe, .writeProtect,
  .sizeVariant, .opPending, .memAddr, .rdStrobe, .wrStrobe, .wrAddr, .wrBlocked, .addressed, .readMode, .standby);

`default_nettype wire

//--- dv/sebfe_front_end_test.sv
`timescale 1ns/1ps
`default_nettype none

module sebfe_front_end_test;
  import sebfe_pkg::*;
  localparam logic [3:0] TYPE_CODE = 4'h6; // Arbitrary value.
  logic clk, reset_n, clkEn, sdaOut, sdaOe, writeProtect, opPending, rdStrobe, wrStrobe, wrBlocked;
  logic addressed, readMode, standby;
  logic [2:0] chipSelectInputs;
  logic [1:0] sizeVariant;
  logic [7:0] rdData, wrData, gotData;
  logic [10:0] memAddr, wrAddr, gotAddr;
  logic [7:0] mem [2048];
  wire logic scl, sdaDrv, sdaWire;
  int fails, check_count, wrCnt, blkCnt;

  assign sdaWire = sdaDrv & ~(sdaOe & ~sdaOut);
  assign rdData = mem[memAddr];
  always #5 clk = ~clk;

  sebfe_bus_ctrl bus (.clk(clk), .sdaWire(sdaWire), .scl(scl), .sdaDrv(sdaDrv));
  sebfe_front_end #(.DEV_TYPE_CODE(TYPE_CODE)) dut (.clk(clk), .reset_n(reset_n), .clkEn(clkEn),
    .scl(scl), .sdaIn(sdaWire), .sdaOut(sdaOut), .sdaOe(sdaOe), .chipSelectInputs(chipSelectInputs),
    .writeProtect(writeProtect), .sizeVariant(sizeVariant), .opPending(opPending), .rdData(rdData),
    .memAddr(memAddr), .rdStrobe(rdStrobe), .wrStrobe(wrStrobe), .wrData(wrData), .wrAddr(wrAddr),
    .wrBlocked(wrBlocked), .addressed(addressed), .readMode(readMode), .standby(standby));

  always @(posedge clk) begin
    if (wrStrobe === 1'b1) begin
      wrCnt++;
      gotAddr = wrAddr;
      gotData = wrData;
    end
    if (wrBlocked === 1'b1)
      blkCnt++;
  end

  // ---------------------------------------------------------------------------
  // Checking helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  function automatic logic [10:0] arrMask(input logic [1:0] v);
    case (v)
      VAR_2K: return ARRAY_MASK_2K;
      VAR_4K: return ARRAY_MASK_4K;
      VAR_8K: return ARRAY_MASK_8K;
      default: return ARRAY_MASK_16K;
    endcase
  endfunction

  function automatic logic selHit(input logic [1:0] v, input logic [2:0] s, input logic [2:0] c);
    case (v)
      VAR_2K: return s === c;
      VAR_4K: return s[2:1] === c[2:1];
      VAR_8K: return s[2] === c[2];
      default: return 1'b1;
    endcase
  endfunction

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    logic [7:0] wa, d, r0, r1;
    logic [2:0] sel, c;
    logic [1:0] v;
    logic typeOk, hit, ack, wp, pend;
    logic [10:0] a;
    void'($urandom(21510));
    {clk, reset_n, clkEn, writeProtect, opPending, sizeVariant, chipSelectInputs} = 10'h080;
    {fails, check_count, wrCnt, blkCnt} = '0;
    foreach (mem[k])
      mem[k] = 8'($urandom);
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    bus.wt(4);
    chk(11'(standby), 11'h001);
    clkEn <= 1'b0;
    bus.start();
    chk(11'({addressed, standby}), 11'h001);
    clkEn <= 1'b1;
    bus.recover();
    bus.stop();
    for (int i = 0; i < 32; i++) begin
      v = 2'(i);
      c = 3'($urandom);
      sel = ($urandom % 2) ? c : 3'($urandom);
      typeOk = ($urandom % 6) != 0;
      hit = typeOk & selHit(v, sel, c);
      wp = ($urandom % 4) == 0;
      pend = $urandom % 2;
      wa = 8'($urandom);
      d = 8'($urandom);
      a = {sel, wa} & arrMask(v);
      sizeVariant <= v;
      chipSelectInputs <= c;
      writeProtect <= wp;
      {wrCnt, blkCnt} = '0;
      bus.start();
      bus.byteTx({typeOk ? TYPE_CODE : ~TYPE_CODE, sel, 1'b0}, ack);
      chk(11'(ack), 11'(hit));
      if (hit) begin
        bus.byteTx(wa, ack);
        chk(11'(ack), 11'h001);
        bus.byteTx(d, ack);
        chk(11'(ack), 11'h001);
        bus.wt(4);
        chk(11'({wrCnt[3:0], blkCnt[3:0]}), {3'h0, 4'(!wp), 4'(wp)});
        if (!wp) begin
          chk(gotAddr, a);
          chk(11'(gotData), 11'(d));
          mem[a] = d;
        end
        bus.start();
        bus.byteTx({TYPE_CODE, sel, 1'b0}, ack);
        bus.byteTx(wa, ack);
        bus.start();
        bus.byteTx({TYPE_CODE, sel, 1'b1}, ack);
        chk(11'(ack), 11'h001);
        bus.byteRx(1'b1, r0);
        bus.byteRx(1'b0, r1);
        chk(11'(r0), 11'(mem[a]));
        chk(11'(r1), 11'(mem[(a + 11'h001) & arrMask(v)]));
      end else
        chk(11'({addressed, standby}), 11'h001);
      opPending <= pend;
      bus.stop();
      bus.wt(4);
      chk(11'(standby), 11'(!pend));
      opPending <= 1'b0;
    end
    report_and_stop();
  end

  // About 650 clocks per pass; roughly four times the whole run before giving up.
  initial begin
    #840_000;
    fails++;
    report_and_stop();
  end
endmodule // sebfe_front_end_test

`default_nettype wire
